// File: srh_pkg.sv
// Constants and types shared by the status reporting hierarchy
package srh_pkg;

  // ==========================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] SRH_OPER_COND  = 8'h00;
  localparam logic [7:0] SRH_OPER_RISE  = 8'h04;
  localparam logic [7:0] SRH_OPER_FALL  = 8'h08;
  localparam logic [7:0] SRH_OPER_EVENT = 8'h0C;
  localparam logic [7:0] SRH_OPER_EN    = 8'h10;
  localparam logic [7:0] SRH_QUES_COND  = 8'h14;
  localparam logic [7:0] SRH_QUES_RISE  = 8'h18;
  localparam logic [7:0] SRH_QUES_FALL  = 8'h1C;
  localparam logic [7:0] SRH_QUES_EVENT = 8'h20;
  localparam logic [7:0] SRH_QUES_EN    = 8'h24;
  localparam logic [7:0] SRH_STD_LATCH  = 8'h28;
  localparam logic [7:0] SRH_STD_MASK   = 8'h2C;
  localparam logic [7:0] SRH_SUMMARY    = 8'h30;
  localparam logic [7:0] SRH_REQ_MASK   = 8'h34;
  localparam logic [7:0] SRH_RMT_CTRL   = 8'h38;
  localparam logic [7:0] SRH_RMT_STAT   = 8'h3C;

  // ==========================================================
  // Reset values and field positions
  localparam logic [14:0] SRH_RISE_RESET = 15'h7FFF;
  localparam logic [14:0] SRH_FALL_RESET = 15'h0000;
  localparam int unsigned SRH_STB_ERR  = 2;
  localparam int unsigned SRH_STB_QUES = 3;
  localparam int unsigned SRH_STB_MSG  = 4;
  localparam int unsigned SRH_STB_STD  = 5;
  localparam int unsigned SRH_STB_MSS  = 6;
  localparam int unsigned SRH_STB_OPER = 7;
  localparam logic [7:0]  SRH_STB_SUM_MASK = 8'hBF;
  localparam int unsigned SRH_CTRL_DISP = 0;
  localparam int unsigned SRH_STAT_RMT  = 0;
  localparam int unsigned SRH_STAT_DISP = 1;

  // ==========================================================
  // Types
  typedef enum logic {SRH_LOCAL, SRH_REMOTE} srh_mode_t;

  typedef struct packed {
    logic [14:0] cond;
    logic [14:0] rise_filt;
    logic [14:0] fall_filt;
    logic [14:0] ev;
    logic [14:0] en;
  } srh_scpi_t;

  typedef struct packed {
    logic [7:0] std;
    logic       cmd;
    logic       go_remote;
    logic       go_local;
    logic       closed;
    logic       local_key;
    logic       view_key;
  } srh_evt_t;

  typedef struct packed {
    logic [14:0] oper;
    logic [14:0] ques;
    logic        err;
    logic        msg;
    srh_evt_t    evt;
  } srh_pins_t;

  typedef struct packed {
    srh_pins_t   s1;
    srh_pins_t   s2;
    srh_evt_t    prev;
    srh_scpi_t   oper;
    srh_scpi_t   ques;
    logic [7:0]  std_ev;
    logic [7:0]  std_mask;
    logic [7:0]  stb;
    logic [7:0]  req_mask;
    srh_mode_t   mode;
    logic        disp;
    logic        remote_o;
    logic        panel_o;
    logic        disp_o;
    logic        service_request;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } srh_state_t;

endpackage

// File: srh_top.sv
// Status reporting hierarchy with local/remote control and APB access
//
// Summary of operation
// R1: Bit 15 of every status register part always reads as zero.
// R2: Each status source owns one bit position across all parts.
// R3: Condition follows present status; summary positions OR enabled events.
// R4: Condition part is read-only; writes and reads never change it.
// R5: A rising condition edge sets its event bit when its rise filter is 1.
// R6: Rise filter resets to all ones.
// R7: A falling condition edge sets its event bit when its fall filter is 1.
// R8: Fall filter resets to all zeros.
// R9: Both filters are read/write; reading leaves them unchanged.
// R10: Event bits latch filtered transitions only and hold until read.
// R11: Event part is read-only; a read returns then clears it.
// R12: Summary bit is the OR of event bits ANDed with enable bits.
// R13: Enable mask is read/write; reading leaves it unchanged.
// R14: Summary byte and request mask sit at the top of the hierarchy.
// R15: Summary byte collects standard latch, operation and questionable sums.
// R16: Message waiting bit is set while a reply is queued.
// R17: All status registers share the same condition/filter/event/enable form; the standard latch here has only event and mask parts.
// R18: Local after reset; a command or go-remote message enters remote.
// R19: Remote disables panel, blanks display, shows local and view keys.
// R20: Link close, local key or go-local message returns to local.
// R21: Controller enables display updates itself when it needs results.
// R22: Summary bits: error 2, questionable 3, message 4, standard 5, oper 7.
// R23: Masked summary bit rising raises a service request; bit 6 mask ignored.
// R24: Edges compare against last cycle; reset restores filters, clears events.
// R25: An event arriving during its clearing read stays set.
`timescale 1ns/1ps
module srh_top
  import srh_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [14:0] OPER_COND,
  input  wire logic [14:0] QUES_COND,
  input  wire logic [7:0]  STD_EVENT,
  input  wire logic        ERR_QUEUE_NONEMPTY,
  input  wire logic        MESSAGE_WAITING,
  input  wire logic        CMD_SEEN,
  input  wire logic        GO_REMOTE,
  input  wire logic        GO_LOCAL,
  input  wire logic        LINK_CLOSED,
  input  wire logic        LOCAL_KEY,
  input  wire logic        VIEW_KEY,
  output logic             REMOTE,
  output logic             PANEL_ENABLE,
  output logic             DISPLAY_ON,
  output logic             SOFT_KEYS_ON,
  output logic             SERVICE_REQUEST,
  output logic      [7:0]  SUMMARY_BYTE
);

  // ==========================================================
  // Helpers
  function automatic logic [14:0] filt_set(input srh_scpi_t r,
                                           input logic [14:0] now);
    filt_set = (now & ~r.cond & r.rise_filt)  // R5
             | (~now & r.cond & r.fall_filt); // R7
  endfunction

  // Same handling for the operation and questionable registers
  function automatic srh_scpi_t scpi_step(input srh_scpi_t   r,
                                          input logic [14:0] now,
                                          input logic [14:0] clr);
    srh_scpi_t q;
    q      = r;
    q.cond = now;                                  // R3 R17
    q.ev   = (r.ev & ~clr) | filt_set(r, now);     // R10 R25
    return q;
  endfunction

  function automatic logic [31:0] z15(input logic [14:0] v);
    z15 = {17'h0_0000, v};                         // R1
  endfunction

  function automatic logic [31:0] z8(input logic [7:0] v);
    z8 = {24'h00_0000, v};
  endfunction

  // ==========================================================
  // State
  srh_state_t  st_ff;
  srh_state_t  nxt_st;
  srh_pins_t   pin_now;
  srh_evt_t    evt_rise;
  logic        apb_setup;
  logic        apb_done;
  logic        wr_done;
  logic        to_remote;
  logic        to_local;
  logic [14:0] oper_set;
  logic [14:0] ques_set;
  logic [14:0] oper_clr;
  logic [14:0] ques_clr;
  logic [7:0]  std_clr;
  logic [7:0]  stb_now;
  logic [7:0]  stb_rise;

  always_comb begin
    nxt_st = st_ff;

    // Two-stage capture of every status and event pin before use
    pin_now.oper           = OPER_COND;
    pin_now.ques           = QUES_COND;
    pin_now.err            = ERR_QUEUE_NONEMPTY;
    pin_now.msg            = MESSAGE_WAITING;
    pin_now.evt.std        = STD_EVENT;
    pin_now.evt.cmd        = CMD_SEEN;
    pin_now.evt.go_remote  = GO_REMOTE;
    pin_now.evt.go_local   = GO_LOCAL;
    pin_now.evt.closed     = LINK_CLOSED;
    pin_now.evt.local_key  = LOCAL_KEY;
    pin_now.evt.view_key   = VIEW_KEY;
    nxt_st.s1   = pin_now;
    nxt_st.s2   = st_ff.s1;
    nxt_st.prev = st_ff.s2.evt;
    evt_rise    = st_ff.s2.evt & ~st_ff.prev;      // R24

    // ========================================================
    // APB: setup cycle latches read data, access ends next edge
    apb_setup = PSEL & ~PENABLE;
    apb_done  = PSEL & PENABLE & st_ff.pready;
    wr_done   = apb_done & PWRITE;
    nxt_st.pready = apb_setup;
    if (apb_setup) begin
      nxt_st.prdata  = 32'h0000_0000;
      nxt_st.pslverr = 1'b0;
      case (PADDR)
        SRH_OPER_COND:  nxt_st.prdata = z15(st_ff.oper.cond);
        SRH_OPER_RISE:  nxt_st.prdata = z15(st_ff.oper.rise_filt); // R9
        SRH_OPER_FALL:  nxt_st.prdata = z15(st_ff.oper.fall_filt); // R9
        SRH_OPER_EVENT: nxt_st.prdata = z15(st_ff.oper.ev);
        SRH_OPER_EN:    nxt_st.prdata = z15(st_ff.oper.en);        // R13
        SRH_QUES_COND:  nxt_st.prdata = z15(st_ff.ques.cond);
        SRH_QUES_RISE:  nxt_st.prdata = z15(st_ff.ques.rise_filt);
        SRH_QUES_FALL:  nxt_st.prdata = z15(st_ff.ques.fall_filt);
        SRH_QUES_EVENT: nxt_st.prdata = z15(st_ff.ques.ev);
        SRH_QUES_EN:    nxt_st.prdata = z15(st_ff.ques.en);
        SRH_STD_LATCH:  nxt_st.prdata = z8(st_ff.std_ev);
        SRH_STD_MASK:   nxt_st.prdata = z8(st_ff.std_mask);
        SRH_SUMMARY:    nxt_st.prdata = z8(st_ff.stb);
        SRH_REQ_MASK:   nxt_st.prdata = z8(st_ff.req_mask);
        SRH_RMT_CTRL:   nxt_st.prdata = {31'h0000_0000, st_ff.disp};
        SRH_RMT_STAT:   nxt_st.prdata = {30'h0000_0000, st_ff.disp_o,
                                         st_ff.remote_o};
        default:        nxt_st.pslverr = 1'b1;
      endcase
    end

    // Clear only the bits that were returned, so late events survive
    oper_clr = 15'h0000;
    ques_clr = 15'h0000;
    std_clr  = 8'h00;
    if (apb_done && !PWRITE) begin
      if (PADDR == SRH_OPER_EVENT) begin
        oper_clr = st_ff.prdata[14:0];             // R11 R25
      end
      if (PADDR == SRH_QUES_EVENT) begin
        ques_clr = st_ff.prdata[14:0];             // R11 R25
      end
      if (PADDR == SRH_STD_LATCH) begin
        std_clr = st_ff.prdata[7:0];               // R11 R25
      end
    end

    // ========================================================
    // Status registers
    oper_set      = filt_set(st_ff.oper, st_ff.s2.oper);
    ques_set      = filt_set(st_ff.ques, st_ff.s2.ques);
    nxt_st.oper   = scpi_step(st_ff.oper, st_ff.s2.oper, oper_clr); // R2
    nxt_st.ques   = scpi_step(st_ff.ques, st_ff.s2.ques, ques_clr); // R2
    nxt_st.std_ev = (st_ff.std_ev & ~std_clr) | evt_rise.std;       // R25

    // Writes to condition, event and summary addresses are dropped
    if (wr_done) begin
      case (PADDR)
        SRH_OPER_RISE: nxt_st.oper.rise_filt = PWDATA[14:0];   // R9
        SRH_OPER_FALL: nxt_st.oper.fall_filt = PWDATA[14:0];   // R9
        SRH_OPER_EN:   nxt_st.oper.en        = PWDATA[14:0];   // R13
        SRH_QUES_RISE: nxt_st.ques.rise_filt = PWDATA[14:0];   // R9
        SRH_QUES_FALL: nxt_st.ques.fall_filt = PWDATA[14:0];   // R9
        SRH_QUES_EN:   nxt_st.ques.en        = PWDATA[14:0];   // R13
        SRH_STD_MASK:  nxt_st.std_mask       = PWDATA[7:0];
        SRH_REQ_MASK:  nxt_st.req_mask       = PWDATA[7:0];
        default: begin                                         // R4 R11
          nxt_st.pslverr = st_ff.pslverr;
        end
      endcase
    end

    // ========================================================
    // Summary byte and service request
    stb_now = 8'h00;
    stb_now[SRH_STB_ERR]  = st_ff.s2.err;                         // R22
    stb_now[SRH_STB_QUES] = |(st_ff.ques.ev & st_ff.ques.en);     // R12
    stb_now[SRH_STB_MSG]  = st_ff.s2.msg;                         // R16
    stb_now[SRH_STB_STD]  = |(st_ff.std_ev & st_ff.std_mask);     // R15
    stb_now[SRH_STB_OPER] = |(st_ff.oper.ev & st_ff.oper.en);     // R12
    stb_now[SRH_STB_MSS]  = |(stb_now & st_ff.req_mask
                              & SRH_STB_SUM_MASK);                // R14
    stb_rise   = stb_now & ~st_ff.stb & st_ff.req_mask
               & SRH_STB_SUM_MASK;                                // R23
    nxt_st.stb = stb_now;                                         // R3
    nxt_st.service_request = |stb_rise;                                       // R23

    // ========================================================
    // Local / remote; leaving remote wins a tie
    to_local  = evt_rise.closed | evt_rise.local_key
              | evt_rise.go_local;                                // R20
    to_remote = evt_rise.cmd | evt_rise.go_remote;                // R18
    if (wr_done && PADDR == SRH_RMT_CTRL) begin
      nxt_st.disp = PWDATA[SRH_CTRL_DISP];
    end
    case (st_ff.mode)
      SRH_LOCAL: begin
        if (to_remote && !to_local) begin
          nxt_st.mode = SRH_REMOTE;                               // R18
          nxt_st.disp = 1'b0;                                     // R19
        end
      end
      SRH_REMOTE: begin
        if (to_local) begin
          nxt_st.mode = SRH_LOCAL;                                // R20
        end else if (evt_rise.view_key) begin
          nxt_st.disp = ~st_ff.disp;
        end
      end
      default: begin
        nxt_st.mode = SRH_LOCAL;
      end
    endcase
    nxt_st.remote_o = (nxt_st.mode == SRH_REMOTE);
    nxt_st.panel_o  = (nxt_st.mode == SRH_LOCAL);                 // R19
    nxt_st.disp_o   = (nxt_st.mode == SRH_LOCAL) | nxt_st.disp;   // R19
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      st_ff                <= '0;
      st_ff.oper.rise_filt <= SRH_RISE_RESET;                     // R6 R24
      st_ff.ques.rise_filt <= SRH_RISE_RESET;                     // R6 R24
      st_ff.oper.fall_filt <= SRH_FALL_RESET;                     // R8 R24
      st_ff.ques.fall_filt <= SRH_FALL_RESET;                     // R8 R24
      st_ff.mode           <= SRH_LOCAL;                          // R18
      st_ff.panel_o        <= 1'b1;
      st_ff.disp_o         <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA          = st_ff.prdata;
  assign PREADY          = st_ff.pready;
  assign PSLVERR         = st_ff.pslverr;
  assign REMOTE          = st_ff.remote_o;
  assign PANEL_ENABLE    = st_ff.panel_o;
  assign DISPLAY_ON      = st_ff.disp_o;
  assign SOFT_KEYS_ON    = st_ff.remote_o;                        // R19
  assign SERVICE_REQUEST = st_ff.service_request;
  assign SUMMARY_BYTE    = st_ff.stb;

  // ==========================================================
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  sequence s_ev_read;
    apb_done && !PWRITE && PADDR == SRH_OPER_EVENT;
  endsequence

  sequence s_enter_remote;
    st_ff.mode == SRH_LOCAL && to_remote && !to_local && !wr_done;
  endsequence

  chk_reads_positive: assert property ( // R1
    PREADY |-> PRDATA[31:15] == 17'h0_0000)
    else $error("read data above bit 14 not zero");

  chk_filter_reset: assert property ( // R6 R8 R24
    @(posedge MCLK) disable iff (1'b0)
    SRST |=> st_ff.oper.rise_filt == SRH_RISE_RESET
         && st_ff.ques.fall_filt == SRH_FALL_RESET
         && st_ff.oper.ev == 15'h0000)
    else $error("filters or events wrong after reset");

  chk_edge_capture: assert property ( // R5 R7
    |oper_set |=> (st_ff.oper.ev & $past(oper_set)) == $past(oper_set))
    else $error("filtered edge not latched");

  chk_only_filtered: assert property ( // R10
    (st_ff.oper.ev & ~$past(st_ff.oper.ev) & ~$past(oper_set)) == 15'h0)
    else $error("event bit set without filtered edge");

  chk_cond_readonly: assert property ( // R3 R4
    st_ff.oper.cond == $past(st_ff.s2.oper))
    else $error("condition part does not track status");

  chk_read_clears: assert property ( // R11 R25
    s_ev_read |=> (st_ff.oper.ev & $past(st_ff.prdata[14:0])
                   & ~$past(oper_set)) == 15'h0)
    else $error("event read did not clear returned bits");

  chk_oper_summary: assert property ( // R12 R15
    |(st_ff.oper.ev & st_ff.oper.en) |=> SUMMARY_BYTE[SRH_STB_OPER])
    else $error("operation summary bit missing");

  chk_msg_bit: assert property ( // R16 R22
    st_ff.s2.msg |=> SUMMARY_BYTE[SRH_STB_MSG])
    else $error("message waiting bit missing");

  chk_srq_cause: assert property ( // R23
    SERVICE_REQUEST == |(SUMMARY_BYTE & ~$past(SUMMARY_BYTE)
                         & $past(st_ff.req_mask) & SRH_STB_SUM_MASK))
    else $error("service request does not match masked rise");

  chk_remote_entry: assert property ( // R18 R19
    s_enter_remote |=> REMOTE && !PANEL_ENABLE && !DISPLAY_ON
                       && SOFT_KEYS_ON)
    else $error("remote entry wrong");

  chk_local_return: assert property ( // R20
    st_ff.mode == SRH_REMOTE && to_local |=> !REMOTE ##0 PANEL_ENABLE
                                             ##0 DISPLAY_ON)
    else $error("return to local wrong");

  chk_ques_capture: assert property ( // R5 R7 R17
    |ques_set |=> (st_ff.ques.ev & $past(ques_set)) == $past(ques_set))
    else $error("questionable edge not latched");

  chk_std_summary: assert property ( // R15
    |(st_ff.std_ev & st_ff.std_mask) |=> SUMMARY_BYTE[SRH_STB_STD])
    else $error("standard event summary bit missing");

  chk_err_bit: assert property ( // R22
    st_ff.s2.err |=> SUMMARY_BYTE[SRH_STB_ERR])
    else $error("error queue bit missing");

endmodule

// File: srh_ctrl_model.sv
// Remote controller model: APB master issuing register accesses
`timescale 1ns/1ps
module srh_ctrl_model
  import srh_pkg::*;
(
  input  wire logic        mclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // ==========================================================
  // One transfer, waiting as long as the slave needs
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // No cycle count assumed; only the bench timeout ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released bus is inverted so stale values never look valid
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

// File: srh_top_bench.sv
// Self-checking bench for the status reporting hierarchy
`timescale 1ns/1ps
module srh_top_bench
  import srh_pkg::*;
;
  logic        clk, srst, psel, pen, pwr, prdy, perr, err, errq, msgw;
  logic        view, rmt, pnl, disp, keys, service_request;
  logic [7:0]  padr, std, stb, b;
  logic [31:0] pwd, prd, rdat, v;
  logic [14:0] oc, qc, r, f, c;
  logic [4:0]  rq;
  logic [7:0]  posb [5] = '{8'h80, 8'h08, 8'h20, 8'h04, 8'h10};
  int          n_fail = 0, num_checks = 0, ncyc = 0, srq_n = 0, n;

  always #5 clk = ~clk;

  srh_ctrl_model srh_ctrl_model_i (.mclk(clk), .psel(psel), .penable(pen),
    .pwrite(pwr), .paddr(padr), .pwdata(pwd), .prdata(prd), .pready(prdy),
    .pslverr(perr));

  srh_top srh_top_i (.MCLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .OPER_COND(oc), .QUES_COND(qc), .STD_EVENT(std),
    .ERR_QUEUE_NONEMPTY(errq), .MESSAGE_WAITING(msgw), .CMD_SEEN(rq[0]),
    .GO_REMOTE(rq[1]), .GO_LOCAL(rq[2]), .LINK_CLOSED(rq[3]),
    .LOCAL_KEY(rq[4]), .VIEW_KEY(view), .REMOTE(rmt), .PANEL_ENABLE(pnl),
    .DISPLAY_ON(disp), .SOFT_KEYS_ON(keys), .SERVICE_REQUEST(service_request),
    .SUMMARY_BYTE(stb));

  // ==========================================================
  // Helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk) begin
    ncyc++;
    if (service_request === 1'b1)
      srq_n++;
    if (ncyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkf(input logic got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    srh_ctrl_model_i.xfer(1'b0, a, 32'h0, rdat, err);
    chk(rdat, e);
    chkf(err, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    srh_ctrl_model_i.xfer(1'b1, a, d, rdat, err);
  endtask

  task automatic pulse(input int i);
    rq[i] <= 1'b1;
    cyc(5);
    rq[i] <= 1'b0;
    cyc(5);
  endtask

  // Raise or drop one summary source; dropping also drains its latch
  task automatic src(input int s, input logic on);
    logic [7:0] ad;
    ad = s == 2 ? SRH_STD_LATCH : (s ? SRH_QUES_EVENT : SRH_OPER_EVENT);
    case (s)
      0: oc <= {14'h0, on};
      1: qc <= {14'h0, on};
      2: std <= {7'h0, on};
      3: errq <= on;
      default: msgw <= on;
    endcase
    if (!on && s < 3) begin
      cyc(5);
      wr(ad, 32'h0);
      rd(ad, 32'h1);
      rd(ad, 32'h0);
    end
  endtask

  function automatic logic [31:0] ev_exp(input logic [14:0] c0, c1, rf, ff);
    return {17'h0, (~c0 & c1 & rf) | (c0 & ~c1 & ff)};
  endfunction

  function automatic logic [7:0] stb_exp(input logic [7:0] s, m);
    return s | {1'b0, |(s & m & 8'hBF), 6'h0};
  endfunction

  // ==========================================================
  // Scenarios
  initial begin
    clk = 1'b0; srst = 1'b1; oc = '0; qc = '0; std = '0; c = '0;
    errq = 1'b0; msgw = 1'b0; rq = '0; view = 1'b0;
    v = $urandom(32'h02cf);
    cyc(6);
    srst <= 1'b0;
    cyc(3);
    chk({28'h0, rmt, pnl, disp, keys}, 32'h6);
    for (int k = 0; k < 2; k++) begin
      b = k ? SRH_QUES_COND : SRH_OPER_COND;
      rd(b + 8'h04, 32'h7FFF);
      rd(b + 8'h08, 32'h0);
      for (int a = 4; a <= 16; a += 4) begin
        if (a == 12) continue;
        v = $urandom();
        wr(b + a[7:0], v);
        rd(b + a[7:0], {17'h0, v[14:0]});
        rd(b + a[7:0], {17'h0, v[14:0]});
      end
      c = 15'($urandom());
      if (k) qc <= c; else oc <= c;
      cyc(5);
      rd(b, {17'h0, c});
      wr(b, ~{17'h0, c});
      rd(b, {17'h0, c});
      for (int i = 0; i < 6; i++) begin
        r = i ? 15'($urandom()) : SRH_RISE_RESET;
        f = i ? 15'($urandom()) : SRH_FALL_RESET;
        v = $urandom();
        wr(b + 8'h04, {17'h0, r});
        wr(b + 8'h08, {17'h0, f});
        wr(b + 8'h0C, 32'h0);
        srh_ctrl_model_i.xfer(1'b0, b + 8'h0C, 32'h0, rdat, err);
        if (k) qc <= v[14:0]; else oc <= v[14:0];
        cyc(5);
        rd(b + 8'h0C, ev_exp(c, v[14:0], r, f));
        rd(b + 8'h0C, 32'h0);
        c = v[14:0];
      end
      if (k) qc <= 15'h0; else oc <= 15'h0;
      cyc(5);
      srh_ctrl_model_i.xfer(1'b0, b + 8'h0C, 32'h0, rdat, err);
      if (k) qc <= 15'h7FFF; else oc <= 15'h7FFF;
      cyc(3);
      if (k) qc <= 15'h0; else oc <= 15'h0;
      cyc(5);
      rd(b + 8'h0C, {17'h0, r | f});
    end
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(3);
    rd(SRH_OPER_RISE, 32'h7FFF);
    rd(SRH_QUES_FALL, 32'h0);
    rd(SRH_OPER_EVENT, 32'h0);
    for (int j = 0; j < 3; j++) begin
      srh_ctrl_model_i.xfer(j[0], 8'h40 + 8'(j * 94), 32'h1, rdat, err);
      chkf(err, 1'b1);
    end
    wr(SRH_OPER_EN, 32'h1);
    wr(SRH_QUES_EN, 32'h1);
    wr(SRH_STD_MASK, 32'h1);
    for (int m = 0; m < 2; m++) begin
      wr(SRH_REQ_MASK, m ? 32'h40 : 32'hFF);
      for (int s = 0; s < 5; s++) begin
        n = srq_n;
        src(s, 1'b1);
        cyc(6);
        b = stb_exp(posb[s], m ? 8'h40 : 8'hFF);
        chk({24'h0, stb}, {24'h0, b});
        chk(srq_n - n, m ? 0 : 1);
        rd(SRH_SUMMARY, {24'h0, b});
        src(s, 1'b0);
        cyc(6);
        chk({24'h0, stb}, 32'h0);
      end
    end
    for (int i = 0; i < 3; i++) begin
      pulse(i % 2);
      chk({28'h0, rmt, pnl, disp, keys}, 32'h9);
      rd(SRH_RMT_STAT, 32'h1);
      view <= 1'b1;
      cyc(5);
      view <= 1'b0;
      cyc(5);
      chkf(disp, 1'b1);
      wr(SRH_RMT_CTRL, 32'h0);
      cyc(1);
      chkf(disp, 1'b0);
      rd(SRH_RMT_CTRL, 32'h0);
      pulse(2 + i);
      chk({28'h0, rmt, pnl, disp, keys}, 32'h6);
    end
    finish_test();
  end
endmodule
